//--- ala_adv_reg.sv
`timescale 1ns/1ps

// Operation
// RULE_01 - Software restarts negotiation after non-default write.
// RULE_02 - Pause bits are the requested flow-control mode.
// RULE_03 - Resolved flow mode reported elsewhere, not here.
// RULE_04 - Bit 15 advertises a next-page request.
// RULE_05 - Bits 13:12 carry remote-fault code, bit 12 first.
// RULE_06 - Remote-fault bits clear after successful page exchange.
// RULE_07 - Bit 8 selects asymmetric or symmetric pause.
// RULE_08 - Bit 7 set advertises able and willing pause.
// RULE_09 - Bit 7 clear advertises no pause.
// RULE_10 - Half-duplex bit always reads zero.
// RULE_11 - Full-duplex bit always reads one.
// RULE_12 - Only bits 7, 8, 12, 13, 15 writable.
// RULE_13 - Reserved bits read zero, read-only writes ignored.
module ala_adv_reg (
  input  wire logic                  clk_sys_i,
  input  wire logic                  srst_i,
  input  wire ala_pkg::ala_cpu_req_s cpu_req_i,
  input  wire logic                  page_exch_done_i,
  input  wire logic                  coding_sublayer_mode_i,
  input  wire logic                  an_disable_i,
  output logic [15:0]                cpu_rdata_o,
  output logic                       cpu_rvalid_o,
  output logic [15:0]                adv_page_o,
  output logic                       next_page_request_o,
  output logic [1:0]                 remote_fault_code_o,
  output logic                       pause_req_valid_o,
  output logic                       asymmetric_pause_request_o,
  output logic                       pause_request_o
);

  logic [15:0] adv;
  logic [15:0] next_adv;
  logic [15:0] next_cpu_rdata;
  logic        next_cpu_rvalid;
  logic        next_next_page;
  logic [1:0]  next_fault_code;
  logic        next_pause_valid;
  logic        next_asym;
  logic        next_pause;
  logic        hit;
  logic [15:0] lane_mask;

  // Both byte addresses of the word select the register; lanes pick the bytes.
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == ala_pkg::ADV_ADDR_LO) || (a == ala_pkg::ADV_ADDR_HI);
  endfunction

  always_comb begin
    hit            = addr_hit(cpu_req_i.addr);
    lane_mask      = {{8{cpu_req_i.be[1]}}, {8{cpu_req_i.be[0]}}};
    next_adv       = adv;
    // A completed page exchange drops the fault code. A software write in the
    // same cycle is applied after it, so a freshly written code is not lost.
    if (page_exch_done_i) begin
      next_adv = next_adv & ~ala_pkg::ADV_FAULT_MASK; // RULE_06
    end
    if (cpu_req_i.wr && hit) begin
      next_adv = (next_adv & ~(ala_pkg::ADV_WR_MASK & lane_mask))
               | (cpu_req_i.wdata & ala_pkg::ADV_WR_MASK & lane_mask); // RULE_12
    end
    // Everything outside the writable set is forced to its fixed value.
    next_adv = (next_adv & ala_pkg::ADV_WR_MASK) | ala_pkg::ADV_FIXED_ONE; // RULE_13 RULE_10 RULE_11

    next_cpu_rvalid = cpu_req_i.rd;
    next_cpu_rdata  = 16'h0000;
    if (cpu_req_i.rd && hit) begin
      next_cpu_rdata = adv;
    end

    next_next_page   = next_adv[ala_pkg::NEXT_PAGE_BIT]; // RULE_04
    next_fault_code  = {next_adv[ala_pkg::FAULT_LO_BIT], next_adv[ala_pkg::FAULT_HI_BIT]}; // RULE_05
    // The requested mode only matters while the sublayer negotiates; the
    // resolved result belongs to the sublayer status and never lands here.
    next_pause_valid = coding_sublayer_mode_i && !an_disable_i; // RULE_02 RULE_03
    next_asym        = next_pause_valid && next_adv[ala_pkg::ASYM_BIT]; // RULE_07
    next_pause       = next_pause_valid && next_adv[ala_pkg::PAUSE_BIT]; // RULE_08 RULE_09
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      adv                        <= ala_pkg::ADV_RESET;
      cpu_rdata_o                <= 16'h0000;
      cpu_rvalid_o               <= 1'b0;
      adv_page_o                 <= ala_pkg::ADV_RESET;
      next_page_request_o        <= 1'b0;
      remote_fault_code_o        <= 2'h0;
      pause_req_valid_o          <= 1'b0;
      asymmetric_pause_request_o <= 1'b0;
      pause_request_o            <= 1'b0;
    end else begin
      adv                        <= next_adv;
      cpu_rdata_o                <= next_cpu_rdata;
      cpu_rvalid_o               <= next_cpu_rvalid;
      adv_page_o                 <= next_adv;
      next_page_request_o        <= next_next_page;
      remote_fault_code_o        <= next_fault_code;
      pause_req_valid_o          <= next_pause_valid;
      asymmetric_pause_request_o <= next_asym;
      pause_request_o            <= next_pause;
    end
  end

  AST_FIXED_BITS: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_10 RULE_11 RULE_13
    (adv_page_o & ~ala_pkg::ADV_WR_MASK) == ala_pkg::ADV_FIXED_ONE)
    else $error("Fixed or reserved advertisement bits wrong.");

  AST_WRITE_HI: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_04 RULE_12
    cpu_req_i.wr && addr_hit(cpu_req_i.addr) && cpu_req_i.be[1]
    |=> adv_page_o[15] == $past(cpu_req_i.wdata[15]) && next_page_request_o == adv_page_o[15])
    else $error("Next-page bit did not follow the write.");

  AST_WRITE_LO: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_12
    cpu_req_i.wr && addr_hit(cpu_req_i.addr) && cpu_req_i.be[0]
    |=> adv_page_o[7] == $past(cpu_req_i.wdata[7]))
    else $error("Pause bit did not follow the write.");

  AST_FAULT_CLEAR: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_06
    page_exch_done_i && !(cpu_req_i.wr && addr_hit(cpu_req_i.addr) && cpu_req_i.be[1])
    |=> adv_page_o[13:12] == 2'h0 && remote_fault_code_o == 2'h0)
    else $error("Remote fault not cleared after page exchange.");

  AST_FAULT_ORDER: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_05
    remote_fault_code_o == {adv_page_o[12], adv_page_o[13]})
    else $error("Remote fault code order wrong.");

  AST_PAUSE_REQ: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_02 RULE_07 RULE_08 RULE_09
    ##1 (pause_req_valid_o == ($past(coding_sublayer_mode_i) && !$past(an_disable_i)))
    && (pause_request_o == (pause_req_valid_o && adv_page_o[7]))
    && (asymmetric_pause_request_o == (pause_req_valid_o && adv_page_o[8])))
    else $error("Requested flow-control mode wrong.");

  AST_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_03
    !cpu_req_i.wr && !page_exch_done_i |=> $stable(adv_page_o))
    else $error("Advertisement changed without a cause.");

  AST_READ: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_13
    cpu_req_i.rd |=> cpu_rvalid_o
    && cpu_rdata_o == ($past(addr_hit(cpu_req_i.addr)) ? $past(adv_page_o) : 16'h0000))
    else $error("Read data wrong.");

  AST_RESET: assert property (@(posedge clk_sys_i) // RULE_12
    $past(srst_i) && !srst_i |-> adv_page_o == ala_pkg::ADV_RESET)
    else $error("Reset value wrong.");

  // Per-bit write strobes, built from the byte enables apart from the lane mask
  // above, so a slip in the lane mapping shows up in the checks.
  logic [15:0] bit_wr;

  for (genvar gi = 0; gi < 16; gi++) begin : g_adv_bit
    assign bit_wr[gi] = cpu_req_i.wr && hit && cpu_req_i.be[gi / 8]
                        && ala_pkg::ADV_WR_MASK[gi];

    if (ala_pkg::ADV_WR_MASK[gi]) begin : g_writable
      AST_BIT_WRITE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_12
        bit_wr[gi]
        |=> adv_page_o[gi] == $past(cpu_req_i.wdata[gi]))
        else $error("Writable advertisement bit did not take the write.");

      AST_BIT_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_06
        !bit_wr[gi] && !(page_exch_done_i && ala_pkg::ADV_FAULT_MASK[gi])
        |=> $stable(adv_page_o[gi]))
        else $error("Writable advertisement bit changed without a cause.");
    end else begin : g_fixed
      AST_BIT_FIXED: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_13
        adv_page_o[gi] == ala_pkg::ADV_FIXED_ONE[gi])
        else $error("Read-only advertisement bit left its fixed value.");
    end
  end

  AST_HALF_DUP: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_10
    !adv_page_o[ala_pkg::HALF_DUP_BIT])
    else $error("Half-duplex ability advertised.");

  AST_FULL_DUP: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_11
    adv_page_o[ala_pkg::FULL_DUP_BIT])
    else $error("Full-duplex ability not advertised.");

  AST_RESERVED: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_13
    (adv_page_o & ~(ala_pkg::ADV_WR_MASK | ala_pkg::ADV_FIXED_ONE)) == 16'h0000)
    else $error("Reserved advertisement bit set.");

  AST_NEXT_PAGE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_04
    next_page_request_o == adv_page_o[ala_pkg::NEXT_PAGE_BIT])
    else $error("Next-page request does not match the page.");

  // The code is sent with bit 12 first, so each value is checked against
  // the two page bits in that order rather than against a shifted copy.
  AST_FAULT_NONE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_05
    adv_page_o[13:12] == 2'h0
    |-> remote_fault_code_o == 2'h0)
    else $error("No-error fault code wrong.");

  AST_FAULT_OFFLINE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_05
    adv_page_o[13:12] == 2'h2
    |-> remote_fault_code_o == 2'h1)
    else $error("Offline fault code wrong.");

  AST_FAULT_LINK: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_05
    adv_page_o[13:12] == 2'h1
    |-> remote_fault_code_o == 2'h2)
    else $error("Link-failure fault code wrong.");

  AST_FAULT_AN_ERR: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_05
    adv_page_o[13:12] == 2'h3
    |-> remote_fault_code_o == 2'h3)
    else $error("Negotiation-error fault code wrong.");

  AST_PAUSE_ON: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_02
    coding_sublayer_mode_i && !an_disable_i
    |=> pause_req_valid_o)
    else $error("Requested flow-control mode not offered.");

  AST_PAUSE_OFF: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_02
    !coding_sublayer_mode_i || an_disable_i
    |=> !pause_req_valid_o && !pause_request_o && !asymmetric_pause_request_o)
    else $error("Flow-control request offered while not negotiating.");

  AST_ASYM_GATED: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_07
    asymmetric_pause_request_o
    |-> pause_req_valid_o)
    else $error("Asymmetric pause requested while not negotiating.");

  AST_ASYM_FOLLOW: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_07
    pause_req_valid_o
    |-> asymmetric_pause_request_o == adv_page_o[ala_pkg::ASYM_BIT])
    else $error("Asymmetric pause request does not match the page.");

  AST_PAUSE_GATED: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_08
    pause_request_o
    |-> pause_req_valid_o)
    else $error("Pause requested while not negotiating.");

  AST_PAUSE_FOLLOW: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_08
    pause_req_valid_o
    |-> pause_request_o == adv_page_o[ala_pkg::PAUSE_BIT])
    else $error("Pause request does not match the page.");

  AST_NO_PAUSE: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_09
    !adv_page_o[ala_pkg::PAUSE_BIT]
    |-> !pause_request_o)
    else $error("Pause offered although the page bit is clear.");

  // The internal word and the outgoing page must never part: the resolved
  // mode has no home here, so nothing but the advertisement may reach it.
  AST_ADV_MIRROR: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_03
    adv_page_o == adv)
    else $error("Outgoing page differs from the register.");

  AST_UNMAPPED_WR: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_13
    cpu_req_i.wr && !addr_hit(cpu_req_i.addr) && !page_exch_done_i
    |=> $stable(adv_page_o))
    else $error("Write to another address changed the page.");

  AST_UNMAPPED_RD: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_13
    cpu_req_i.rd && !addr_hit(cpu_req_i.addr)
    |=> cpu_rvalid_o && cpu_rdata_o == 16'h0000)
    else $error("Read of another address returned data.");

  AST_RD_HIT: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_12
    cpu_req_i.rd && addr_hit(cpu_req_i.addr)
    |=> cpu_rdata_o == $past(adv))
    else $error("Read of the register returned the wrong word.");

  AST_RD_FIXED: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_10 RULE_11
    cpu_rvalid_o
    |-> (cpu_rdata_o & ~ala_pkg::ADV_WR_MASK) == ala_pkg::ADV_FIXED_ONE
        || cpu_rdata_o == 16'h0000)
    else $error("Read-only bits read back wrong.");

  // Read data is cleared between reads so that a stale word is never taken
  // for a fresh answer by a host that samples without the valid strobe.
  AST_RD_QUIET: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE_13
    !cpu_req_i.rd
    |=> !cpu_rvalid_o && cpu_rdata_o == 16'h0000)
    else $error("Read answer without a read.");

  AST_RESET_OUTS: assert property (@(posedge clk_sys_i) // RULE_04
    $past(srst_i) && !srst_i
    |-> !cpu_rvalid_o && cpu_rdata_o == 16'h0000 && !next_page_request_o
        && remote_fault_code_o == 2'h0 && !pause_req_valid_o
        && !pause_request_o && !asymmetric_pause_request_o)
    else $error("Outputs not at their reset values.");

endmodule // ala_adv_reg

//--- ala_pkg.sv
package ala_pkg;

  // Register placement on the CPU port (byte addresses, 16-bit word).
  localparam logic [7:0]  ADV_ADDR_LO   = 8'h58;
  localparam logic [7:0]  ADV_ADDR_HI   = 8'h59;
  localparam logic [15:0] ADV_RESET     = 16'h01a0;

  // Field positions.
  localparam int          NEXT_PAGE_BIT = 15;
  localparam int          FAULT_HI_BIT  = 13;
  localparam int          FAULT_LO_BIT  = 12;
  localparam int          ASYM_BIT      = 8;
  localparam int          PAUSE_BIT     = 7;
  localparam int          HALF_DUP_BIT  = 6;
  localparam int          FULL_DUP_BIT  = 5;

  // Writable positions and positions fixed at one.
  localparam logic [15:0] ADV_WR_MASK   = 16'hb180;
  localparam logic [15:0] ADV_FAULT_MASK = 16'h3000;
  localparam logic [15:0] ADV_FIXED_ONE = 16'h0020;

  // One access from the generic CPU port.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } ala_cpu_req_s;

endpackage

//--- ala_link_partner.sv
`timescale 1ns/1ps
module ala_link_partner (
  input  wire logic clk_sys_i,
  input  wire logic exch_req_i,
  output logic      page_exch_done_o
);
  // One completion per request; a held request would repeat the pulse.
  initial page_exch_done_o = 1'b0;
  always @(negedge clk_sys_i) begin
    page_exch_done_o <= exch_req_i & ~page_exch_done_o;
  end
endmodule // ala_link_partner

//--- autoneg_local_advertisement_test.sv
`timescale 1ns/1ps
module autoneg_local_advertisement_test;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, req = 1'b0, done, csm = 1'b0, dis = 1'b0;
  ala_pkg::ala_cpu_req_s cpu = '0;
  logic [15:0] rdata, page;
  logic [1:0]  fault;
  logic        rvalid, np, pv, asym, pause;
  int          n_mismatch = 0, num_checks = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  ala_link_partner i_ala_link_partner (.clk_sys_i(clk_sys_i), .exch_req_i(req),
    .page_exch_done_o(done));
  ala_adv_reg i_ala_adv_reg (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .cpu_req_i(cpu),
    .page_exch_done_i(done), .coding_sublayer_mode_i(csm), .an_disable_i(dis),
    .cpu_rdata_o(rdata), .cpu_rvalid_o(rvalid), .adv_page_o(page),
    .next_page_request_o(np), .remote_fault_code_o(fault), .pause_req_valid_o(pv),
    .asymmetric_pause_request_o(asym), .pause_request_o(pause));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] be,
                     input logic [15:0] d);
    @(negedge clk_sys_i);
    cpu <= '{wr: w, rd: !w, addr: a, be: be, wdata: d};
    @(negedge clk_sys_i);
    cpu <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    acc(1'b0, a, 2'h3, 16'h0000);
    chk(rvalid, 16'h0001);
    chk(rdata, exp);
  endtask
  task automatic sc_reset;
    chk(page, 16'h01a0);
    rd(8'h58, 16'h01a0);
  endtask
  task automatic sc_write;
    acc(1'b1, 8'h58, 2'h3, 16'hffff);
    chk(page, 16'hb1a0);
    chk(np, 16'h0001);
    rd(8'h59, 16'hb1a0);
    acc(1'b1, 8'h58, 2'h1, 16'h0000);
    chk(page, 16'hb120);
  endtask
  task automatic sc_fault;
    acc(1'b1, 8'h58, 2'h3, 16'h2000);
    chk(fault, 16'h0001);
    acc(1'b1, 8'h58, 2'h3, 16'h1000);
    chk(fault, 16'h0002);
    @(negedge clk_sys_i) req <= 1'b1;
    @(negedge clk_sys_i) req <= 1'b0;
    @(negedge clk_sys_i);
    chk(page, 16'h0020);
    chk(fault, 16'h0000);
  endtask
  task automatic sc_pause;
    csm <= 1'b1;
    acc(1'b1, 8'h58, 2'h3, 16'h0180);
    chk(asym, 16'h0001);
    chk(pause, 16'h0001);
    acc(1'b1, 8'h58, 2'h3, 16'h0000);
    chk(pause, 16'h0000);
    chk(asym, 16'h0000);
    acc(1'b1, 8'h58, 2'h3, 16'h0180);
    dis <= 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk(pv, 16'h0000);
    chk(pause, 16'h0000);
  endtask
  task automatic sc_unmapped;
    acc(1'b1, 8'h5a, 2'h3, 16'hffff);
    chk(page, 16'h01a0);
    rd(8'h5a, 16'h0000);
  endtask
  task automatic finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk_sys_i);
    srst_i <= 1'b0;
    sc_reset();
    sc_write();
    sc_fault();
    sc_pause();
    acc(1'b1, 8'h58, 2'h3, 16'h0180);
    sc_unmapped();
    finish_test();
  end
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    n_mismatch++;
    finish_test();
  end
endmodule // autoneg_local_advertisement_test
